// ===== rsc_rx_src_config_regs.sv
// Receiver and sample rate converter control registers with sample handling
// Functional notes
// - Soft-mute bit ramps converter output to zero
// - Seven-bit field adds FIR delay in samples
// - Unlocked PLL: clock from PLL or internal one
// - Ratio code gives 128, 256, 512 times fs
// - Auto de-emphasis follows received channel status
// - Parity/biphase error: none, hold, or zero
// - Lock loss: none, hold, zeros, soft mute
// - Hard mute zeroes receiver audio output
// - PLL reference: preambles or serial port clock
// - Port select picks playback, aux, record, auxout
// - Nonaudio block bit keeps data from converter
// - Compressed payloads never reach the converter
// - Invalid block bit keeps data from converter
`timescale 1ns/1ns
module rsc_rx_src_config_regs
  import rsc_pkg::*;
#(
  parameter int W = 24
)(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [6:0]   regAddr,
  input  wire logic [7:0]   regWrData,
  input  wire logic         regWrEn,
  output logic      [7:0]   regRdData,
  input  wire logic         pllLockedPin,
  input  wire logic         rxInValid,
  input  wire logic         rxInChan,
  input  wire logic [W-1:0] rxInSample,
  input  wire logic         rxParityErr,
  input  wire logic         rxBiphaseErr,
  input  wire logic         rxValidityFlag,
  input  wire logic         rxNonAudio,
  input  wire logic         rxEmphFlag,
  input  wire logic         srcInValid,
  input  wire logic [W-1:0] srcInSample,
  output logic              rxOutValid,
  output logic              rxOutChan,
  output logic      [W-1:0] rxOutSample,
  output logic              srcFeedValid,
  output logic              srcOutValid,
  output logic      [W-1:0] srcOutSample,
  output logic      [6:0]   firExtraDelay,
  output logic              rxClkUseInternal,
  output logic      [9:0]   rxClkRatio,
  output logic              pllRefFromPort,
  output logic      [3:0]   pllRefPort,
  output logic              deemphActive
);

  // Sample width must leave room for the ramp arithmetic
  if (W < 8) begin : g_bad_width
    $error("rsc_rx_src_config_regs: W below 8");
  end

  // Scale a sample by a ramp gain; full gain passes the sample unchanged
  function automatic logic [W-1:0] scaleSample(input logic [W-1:0] s, input logic [RSC_GAIN_BITS:0] g);
    logic signed [W+RSC_GAIN_BITS+1:0] p;
    p = $signed(s) * $signed({1'b0, g});
    return p[W+RSC_GAIN_BITS-1:RSC_GAIN_BITS];
  endfunction
  logic [7:0]   delayMute_reg, delayMute_next;     // Delay and soft mute register
  logic [7:0]   rxOne_reg, rxOne_next;             // First receiver setup
  logic [7:0]   rxTwo_reg, rxTwo_next;             // Second receiver setup
  logic         lockMeta_reg;                      // Lock synchroniser, first stage
  logic         lockSync_reg;                      // Lock synchroniser, second stage
  logic [W-1:0] lastGood_reg [2], lastGood_next [2]; // Last valid sample per channel
  logic [W-1:0] deemState_reg [2], deemState_next [2]; // Filter state per channel
  logic [RSC_GAIN_BITS:0] lockGain_reg, lockGain_next; // Lock-loss ramp gain
  logic [RSC_GAIN_BITS:0] srcGain_reg, srcGain_next;   // Converter ramp gain
  logic         rxOutValid_reg, rxOutValid_next;
  logic         rxOutChan_reg, rxOutChan_next;
  logic [W-1:0] rxOutSample_reg, rxOutSample_next;
  logic         srcFeed_reg, srcFeed_next;
  logic         srcOutValid_reg, srcOutValid_next;
  logic [W-1:0] srcOutSample_reg, srcOutSample_next;
  logic [1:0]   faultCode, dropCode, ratioCode;    // Decoded fields
  logic         rxErr, pllLost, blockFeed;
  logic [W-1:0] baseSample, deemSample;
  // Field decode
  assign faultCode = rxOne_reg[RSC_FAULT_LSB +: 2];
  assign dropCode  = rxOne_reg[RSC_DROP_LSB +: 2];
  assign ratioCode = rxOne_reg[RSC_RATIO_LSB +: 2];
  assign rxErr     = rxParityErr | rxBiphaseErr;
  assign pllLost   = ~lockSync_reg;
  assign firExtraDelay = delayMute_reg[RSC_DELAY_MSB:0];
  assign rxClkUseInternal = pllLost & rxOne_reg[RSC_UNLOCK_CLK_BIT];
  assign pllRefFromPort = rxTwo_reg[RSC_REF_PORT_BIT];
  assign deemphActive = rxOne_reg[RSC_DEEMPH_BIT] & rxEmphFlag;
  assign rxOutValid   = rxOutValid_reg;
  assign rxOutChan    = rxOutChan_reg;
  assign rxOutSample  = rxOutSample_reg;
  assign srcFeedValid = srcFeed_reg;
  assign srcOutValid  = srcOutValid_reg;
  assign srcOutSample = srcOutSample_reg;
  // Ratio and port decode; reserved ratio reads as 128
  always_comb
  begin
    unique case (ratioCode)
      RSC_RATIO_256: rxClkRatio = RSC_OSR_256;
      RSC_RATIO_512: rxClkRatio = RSC_OSR_512;
      default:       rxClkRatio = RSC_OSR_128;   // reserved code
    endcase
    // one-hot port select, idle while preambles are the reference
    pllRefPort = 4'h0;
    if (pllRefFromPort)
      pllRefPort[rxTwo_reg[RSC_REF_SEL_LSB +: 2]] = 1'b1;
  end

  // Register read; unmapped addresses read zero
  always_comb
  begin
    unique case (regAddr)
      RSC_ADDR_DELAY_MUTE: regRdData = delayMute_reg;
      RSC_ADDR_RX_ONE:     regRdData = rxOne_reg;
      RSC_ADDR_RX_TWO:     regRdData = rxTwo_reg;
      default:             regRdData = RSC_READ_UNMAPPED;
    endcase
  end

  // Register write; reserved bits of the second setup stay zero
  always_comb
  begin
    delayMute_next = delayMute_reg;
    rxOne_next     = rxOne_reg;
    rxTwo_next     = rxTwo_reg;
    if (regWrEn && regAddr == RSC_ADDR_DELAY_MUTE)
      delayMute_next = regWrData;
    if (regWrEn && regAddr == RSC_ADDR_RX_ONE)
      rxOne_next = regWrData;
    if (regWrEn && regAddr == RSC_ADDR_RX_TWO)
      rxTwo_next = regWrData & RSC_RX_TWO_WMASK;
  end
  // Registers and lock synchroniser; lock pin is asynchronous, so two stages before use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      delayMute_reg <= RSC_RST_DELAY_MUTE;
      rxOne_reg     <= RSC_RST_RX_ONE;
      rxTwo_reg     <= RSC_RST_RX_TWO;
      lockMeta_reg  <= 1'b0;
      lockSync_reg  <= 1'b0;
    end
    else
    begin
      delayMute_reg <= delayMute_next;
      rxOne_reg     <= rxOne_next;
      rxTwo_reg     <= rxTwo_next;
      lockMeta_reg  <= pllLockedPin;
      lockSync_reg  <= lockMeta_reg;
    end
  end
  // Receiver sample path: fault, lock loss, de-emphasis, mute, gating
  always_comb
  begin
    lastGood_next   = lastGood_reg;
    deemState_next  = deemState_reg;
    lockGain_next   = lockGain_reg;
    rxOutValid_next = rxInValid;
    rxOutChan_next  = rxOutChan_reg;
    rxOutSample_next = rxOutSample_reg;
    srcFeed_next    = 1'b0;
    baseSample      = rxInSample;
    // error handling, reserved code does nothing
    if (rxErr && faultCode == RSC_CODE_HOLD)
      baseSample = lastGood_reg[rxInChan];
    else if (rxErr && faultCode == RSC_CODE_ZERO)
      baseSample = '0;
    // lock-loss hold, zero and soft codes override the error path
    if (pllLost)
    begin
      unique case (dropCode)
        RSC_CODE_HOLD: baseSample = lastGood_reg[rxInChan];
        RSC_CODE_ZERO: baseSample = '0;
        RSC_CODE_SOFT: baseSample = scaleSample(lastGood_reg[rxInChan], lockGain_reg);
        default:       baseSample = baseSample;
      endcase
    end
    deemSample = deemState_reg[rxInChan] +
                 W'($signed(baseSample - deemState_reg[rxInChan]) >>> RSC_DEEMPH_SHIFT);
    if (rxInValid)
    begin
      rxOutChan_next           = rxInChan;
      deemState_next[rxInChan] = deemSample;
      // hard mute zeroes the sample at once
      rxOutSample_next = rxTwo_reg[RSC_HARD_MUTE_BIT] ? '0 : (deemphActive ? deemSample : baseSample);
      if (!rxErr && !pllLost)
        lastGood_next[rxInChan] = rxInSample;
      // lock-loss ramp steps once per sample
      if (pllLost && dropCode == RSC_CODE_SOFT)
        lockGain_next = (lockGain_reg == RSC_GAIN_ZERO) ? RSC_GAIN_ZERO : lockGain_reg - RSC_GAIN_STEP;
      else
        lockGain_next = RSC_GAIN_FULL;
      srcFeed_next = ~blockFeed;
    end
  end
  assign blockFeed = rxTwo_reg[RSC_BLK_NONAUD_BIT] | rxNonAudio |
                     (rxTwo_reg[RSC_BLK_INVAL_BIT] & rxValidityFlag);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lastGood_reg     <= '{default: '0};
      deemState_reg    <= '{default: '0};
      lockGain_reg     <= RSC_GAIN_FULL;
      rxOutValid_reg   <= 1'b0;
      rxOutChan_reg    <= 1'b0;
      rxOutSample_reg  <= '0;
      srcFeed_reg      <= 1'b0;
    end
    else
    begin
      lastGood_reg     <= lastGood_next;
      deemState_reg    <= deemState_next;
      lockGain_reg     <= lockGain_next;
      rxOutValid_reg   <= rxOutValid_next;
      rxOutChan_reg    <= rxOutChan_next;
      rxOutSample_reg  <= rxOutSample_next;
      srcFeed_reg      <= srcFeed_next;
    end
  end

  // converter output soft mute ramp, one step per sample
  always_comb
  begin
    srcGain_next      = srcGain_reg;
    srcOutValid_next  = srcInValid;
    srcOutSample_next = srcOutSample_reg;
    if (srcInValid)
    begin
      srcOutSample_next = scaleSample(srcInSample, srcGain_reg);
      if (delayMute_reg[RSC_SOFT_MUTE_BIT])
        srcGain_next = (srcGain_reg == RSC_GAIN_ZERO) ? RSC_GAIN_ZERO : srcGain_reg - RSC_GAIN_STEP;
      else
        srcGain_next = (srcGain_reg == RSC_GAIN_FULL) ? RSC_GAIN_FULL : srcGain_reg + RSC_GAIN_STEP;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      srcGain_reg      <= RSC_GAIN_FULL;
      srcOutValid_reg  <= 1'b0;
      srcOutSample_reg <= '0;
    end
    else
    begin
      srcGain_reg      <= srcGain_next;
      srcOutValid_reg  <= srcOutValid_next;
      srcOutSample_reg <= srcOutSample_next;
    end
  end

  // Checks next to the logic they guard
  a_hard_mute_zero: assert property (@(posedge clk) disable iff (!nrst)
    rxInValid && rxTwo_reg[RSC_HARD_MUTE_BIT] |=> rxOutValid && rxOutSample == '0)
    else $error("hard mute let a sample through");
  a_error_zeroed: assert property (@(posedge clk) disable iff (!nrst)
    rxInValid && rxErr && lockSync_reg && faultCode == RSC_CODE_ZERO && !deemphActive
    |=> rxOutSample == '0) else $error("errored sample not zeroed");
  a_lock_hold: assert property (@(posedge clk) disable iff (!nrst)
    rxInValid && pllLost && dropCode == RSC_CODE_HOLD && !deemphActive && !rxTwo_reg[RSC_HARD_MUTE_BIT]
    |=> rxOutSample == $past(lastGood_reg[rxInChan])) else $error("lock loss did not hold");
  a_feed_blocked: assert property (@(posedge clk) disable iff (!nrst)
    rxInValid && rxNonAudio |=> !srcFeedValid) else $error("compressed data fed converter");
  a_feed_valid: assert property (@(posedge clk) disable iff (!nrst)
    rxInValid && !rxNonAudio && !rxValidityFlag && !rxTwo_reg[RSC_BLK_NONAUD_BIT]
    |=> srcFeedValid) else $error("valid frame kept from converter");
  a_unlock_clock: assert property (@(posedge clk) disable iff (!nrst)
    rxClkUseInternal == (!lockSync_reg && rxOne_reg[RSC_UNLOCK_CLK_BIT])) else $error("clock select wrong");
  a_ratio_decode: assert property (@(posedge clk) disable iff (!nrst)
    ratioCode == RSC_RATIO_512 |-> rxClkRatio == RSC_OSR_512) else $error("ratio decode wrong");
  a_ref_port: assert property (@(posedge clk) disable iff (!nrst)
    pllRefFromPort |-> $onehot(pllRefPort)) else $error("reference port not one-hot");
  a_soft_ramp: assert property (@(posedge clk) disable iff (!nrst)
    srcInValid && delayMute_reg[RSC_SOFT_MUTE_BIT] && srcGain_reg != RSC_GAIN_ZERO
    |=> srcGain_reg == $past(srcGain_reg) - RSC_GAIN_STEP) else $error("soft mute ramp stalled");
  a_write_delay: assert property (@(posedge clk) disable iff (!nrst)
    regWrEn && regAddr == RSC_ADDR_DELAY_MUTE |=> firExtraDelay == $past(regWrData[RSC_DELAY_MSB:0]))
    else $error("delay field not written");

endmodule

// ===== rsc_pkg.sv
// Register map, field layout and constants of the receiver and converter control block
package rsc_pkg;
  // Register addresses on the serial control port
  localparam logic [6:0] RSC_ADDR_DELAY_MUTE = 7'h08;
  localparam logic [6:0] RSC_ADDR_RX_ONE     = 7'h09;
  localparam logic [6:0] RSC_ADDR_RX_TWO     = 7'h0a;
  // Reset values, second setup write mask and unmapped read value
  localparam logic [7:0] RSC_RST_DELAY_MUTE  = 8'h00;
  localparam logic [7:0] RSC_RST_RX_ONE      = 8'h00;
  localparam logic [7:0] RSC_RST_RX_TWO      = 8'h00;
  localparam logic [7:0] RSC_RX_TWO_WMASK    = 8'hf3;
  localparam logic [7:0] RSC_READ_UNMAPPED   = 8'h00;
  // Delay and mute fields
  localparam int RSC_SOFT_MUTE_BIT  = 7;
  localparam int RSC_DELAY_MSB      = 6;
  // First receiver setup fields
  localparam int RSC_UNLOCK_CLK_BIT = 7;
  localparam int RSC_RATIO_LSB      = 5;
  localparam int RSC_DEEMPH_BIT     = 4;
  localparam int RSC_FAULT_LSB      = 2;
  localparam int RSC_DROP_LSB       = 0;
  // Second receiver setup fields
  localparam int RSC_HARD_MUTE_BIT  = 7;
  localparam int RSC_REF_PORT_BIT   = 6;
  localparam int RSC_REF_SEL_LSB    = 4;
  localparam int RSC_BLK_NONAUD_BIT = 1;
  localparam int RSC_BLK_INVAL_BIT  = 0;
  // Two-bit field codes
  localparam logic [1:0] RSC_CODE_NONE = 2'h0;
  localparam logic [1:0] RSC_CODE_HOLD = 2'h1;
  localparam logic [1:0] RSC_CODE_ZERO = 2'h2;
  localparam logic [1:0] RSC_CODE_SOFT = 2'h3;
  localparam logic [1:0] RSC_RATIO_256 = 2'h1;
  localparam logic [1:0] RSC_RATIO_512 = 2'h2;
  // Oversampling ratio values
  localparam logic [9:0] RSC_OSR_128   = 10'h080;
  localparam logic [9:0] RSC_OSR_256   = 10'h100;
  localparam logic [9:0] RSC_OSR_512   = 10'h200;
  // Soft mute ramp and de-emphasis filter
  localparam int RSC_GAIN_BITS    = 6;
  localparam logic [RSC_GAIN_BITS:0] RSC_GAIN_FULL = 7'h40;
  localparam logic [RSC_GAIN_BITS:0] RSC_GAIN_ZERO = 7'h00;
  localparam logic [RSC_GAIN_BITS:0] RSC_GAIN_STEP = 7'h01;
  localparam int RSC_DEEMPH_SHIFT = 2;
endpackage

// ===== rsc_feed.sv
// Behavioural model of the external digital audio source
`timescale 1ns/1ns
module rsc_feed
  import rsc_pkg::*;
#(
  parameter int W = 24
)(
  input  wire logic   clk,
  output logic         pllLockedPin,
  output logic         rxInValid,
  output logic         rxInChan,
  output logic [W-1:0] rxInSample,
  output logic         rxParityErr,
  output logic         rxBiphaseErr,
  output logic         rxValidityFlag,
  output logic         rxNonAudio,
  output logic         rxEmphFlag
);
  // Idle source: unlocked, no frame
  initial
  begin
    pllLockedPin = 1'b0;
    rxInValid = 1'b0;
    rxInChan = 1'b0;
    rxInSample = {W{1'b0}};
    {rxParityErr, rxBiphaseErr, rxValidityFlag, rxNonAudio} = 4'h0;
    rxEmphFlag = 1'b0;
  end

  // One frame; f is parity, biphase, validity, non-audio
  task automatic send(input logic ch, input logic [W-1:0] s, input logic [3:0] f);
    @(negedge clk);
    rxInValid = 1'b1;
    rxInChan = ch;
    rxInSample = s;
    {rxParityErr, rxBiphaseErr, rxValidityFlag, rxNonAudio} = f;
    @(negedge clk);
    // Qualifiers die with the strobe, so never leave the old value
    rxInValid = 1'b0;
    rxInChan = ~ch;
    rxInSample = ~s;
    {rxParityErr, rxBiphaseErr, rxValidityFlag, rxNonAudio} = ~f;
  endtask
endmodule

// ===== rx_src_config_regs_tb.sv
// Self-checking bench for the receiver and converter control block
`timescale 1ns/1ns
module rx_src_config_regs_tb
  import rsc_pkg::*;
;
  localparam int W = 24;
  logic         clk = 1'b0;
  logic         nrst, regWrEn, srcInValid;
  logic [6:0]   regAddr, a;
  logic [7:0]   regWrData, regRdData, d;
  logic [W-1:0] srcInSample, rxInSample, rxOutSample, srcOutSample, s, g, x;
  logic         pllLockedPin, rxInValid, rxInChan, rxParityErr, rxBiphaseErr;
  logic         rxValidityFlag, rxNonAudio, rxEmphFlag, rxOutValid, rxOutChan;
  logic         srcFeedValid, srcOutValid, rxClkUseInternal, pllRefFromPort, deemphActive;
  logic [6:0]   firExtraDelay;
  logic [9:0]   rxClkRatio;
  logic [3:0]   pllRefPort;
  int           bad_count = 0;
  int           num_checks = 0;
  integer       seed = 32'h109141a1;

  // 50 MHz clock
  always #10 clk = ~clk;

  rsc_rx_src_config_regs #(.W(W)) rsc_rx_src_config_regs_inst (
    .clk, .nrst, .regAddr, .regWrData, .regWrEn, .regRdData, .pllLockedPin, .rxInValid,
    .rxInChan, .rxInSample, .rxParityErr, .rxBiphaseErr, .rxValidityFlag, .rxNonAudio,
    .rxEmphFlag, .srcInValid, .srcInSample, .rxOutValid, .rxOutChan, .rxOutSample,
    .srcFeedValid, .srcOutValid, .srcOutSample, .firExtraDelay, .rxClkUseInternal,
    .rxClkRatio, .pllRefFromPort, .pllRefPort, .deemphActive);

  rsc_feed #(.W(W)) rsc_feed_inst (
    .clk, .pllLockedPin, .rxInValid, .rxInChan, .rxInSample, .rxParityErr,
    .rxBiphaseErr, .rxValidityFlag, .rxNonAudio, .rxEmphFlag);

  // Expected sample under error or lock-loss code
  function automatic logic [W-1:0] expOf(input int c, input logic [W-1:0] gd, input logic [W-1:0] sn,
                                         input bit lk);
    if (c == 1)
      return gd;
    if (c == 2 || (lk && c == 3))
      return {W{1'b0}};
    // Reserved error code acts as no action
    return sn;
  endfunction

  task automatic chkR(input string n, input logic [9:0] e, input logic [9:0] v);
    num_checks++;
    if (v !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, v);
    end
  endtask

  task automatic chkS(input string n, input logic [W-1:0] e, input logic [W-1:0] v);
    num_checks++;
    if (v !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, v);
    end
  endtask

  // One-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [6:0] ad, input logic [7:0] dt);
    @(negedge clk);
    regAddr = ad;
    regWrData = dt;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // Read port is combinational, so settle then look
  task automatic rdchk(input logic [6:0] ad, input logic [7:0] e);
    regAddr = ad;
    #1;
    chkR("regRdData", 10'(e), 10'(regRdData));
  endtask

  // One converter output sample
  task automatic cvt(input logic [W-1:0] v);
    @(negedge clk);
    srcInValid = 1'b1;
    srcInSample = v;
    @(negedge clk);
    srcInValid = 1'b0;
    srcInSample = ~v;
    chkR("srcOutValid", 10'h001, 10'(srcOutValid));
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    regAddr = 7'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    srcInValid = 1'b0;
    srcInSample = {W{1'b0}};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    for (int n = 8; n < 12; n++)
      rdchk(7'(n), 8'h00);
    chkR("rxClkRatio", RSC_OSR_128, rxClkRatio);
    // Random traffic while still unlocked
    for (int i = 0; i < 12; i++)
    begin
      a = 7'h08 + 7'(i % 3);
      d = 8'($random(seed));
      rsc_feed_inst.rxEmphFlag = d[0];
      wr(a, d);
      rdchk(a, (a == RSC_ADDR_RX_TWO) ? (d & 8'hf3) : d);
      if (a == RSC_ADDR_DELAY_MUTE)
        chkR("firExtraDelay", 10'(d[6:0]), 10'(firExtraDelay));
      else if (a == RSC_ADDR_RX_ONE)
      begin
        chkR("rxClkUseInternal", 10'(d[7]), 10'(rxClkUseInternal));
        chkR("deemphActive", 10'(d[4] & d[0]), 10'(deemphActive));
      end
      else
      begin
        chkR("pllRefPort", d[6] ? 10'(4'h1 << d[5:4]) : 10'h000, 10'(pllRefPort));
        chkR("pllRefFromPort", 10'(d[6]), 10'(pllRefFromPort));
      end
    end
    // Every ratio and port code, reserved ratio included
    for (int c = 0; c < 4; c++)
    begin
      wr(RSC_ADDR_RX_ONE, {1'b0, 2'(c), 5'h00});
      chkR("rxClkRatio", (c == 1) ? 10'h100 : (c == 2) ? 10'h200 : 10'h080, rxClkRatio);
      wr(RSC_ADDR_RX_TWO, {2'b01, 2'(c), 4'hf});
      chkR("pllRefPort", 10'(4'h1 << c), 10'(pllRefPort));
      chkR("pllRefFromPort", 10'h001, 10'(pllRefFromPort));
    end
    wr(7'h0b, 8'hff);
    rdchk(7'h0b, 8'h00);
    wr(RSC_ADDR_RX_ONE, 8'h00);
    rsc_feed_inst.rxEmphFlag = 1'b0;
    rsc_feed_inst.pllLockedPin = 1'b1;
    repeat (3) @(negedge clk);
    // Gating: block bits against validity and non-audio flags
    for (int k = 0; k < 16; k++)
    begin
      wr(RSC_ADDR_RX_TWO, {6'h00, 2'(k)});
      s = W'($random(seed));
      rsc_feed_inst.send(1'b0, s, {2'b00, 2'(k >> 2)});
      chkR("rxOutValid", 10'h001, 10'(rxOutValid));
      chkS("rxOutSample", s, rxOutSample);
      chkR("srcFeedValid", 10'(!(k[1] || k[2] || (k[0] && k[3]))), 10'(srcFeedValid));
    end
    wr(RSC_ADDR_RX_TWO, 8'h00);
    // Parity or biphase error after a good sample
    for (int c = 0; c < 4; c++)
    begin
      wr(RSC_ADDR_RX_ONE, {4'h0, 2'(c), 2'b00});
      g = W'($random(seed));
      rsc_feed_inst.send(1'b0, g, 4'h0);
      s = W'($random(seed));
      rsc_feed_inst.send(1'b0, s, {c[0], !c[0], 2'b00});
      chkS("rxOutSample", expOf(c, g, s, 1'b0), rxOutSample);
    end
    // Lock loss codes; soft mute needs the full ramp
    for (int c = 0; c < 4; c++)
    begin
      wr(RSC_ADDR_RX_ONE, {1'b1, 5'h00, 2'(c)});
      g = W'($random(seed));
      rsc_feed_inst.send(1'b0, g, 4'h0);
      chkR("rxClkUseInternal", 10'h000, 10'(rxClkUseInternal));
      rsc_feed_inst.pllLockedPin = 1'b0;
      repeat (3) @(negedge clk);
      chkR("rxClkUseInternal", 10'h001, 10'(rxClkUseInternal));
      repeat ((c == 3) ? 70 : 1)
      begin
        s = W'($random(seed));
        rsc_feed_inst.send(1'b0, s, 4'h0);
      end
      chkS("rxOutSample", expOf(c, g, s, 1'b1), rxOutSample);
      rsc_feed_inst.pllLockedPin = 1'b1;
      repeat (3) @(negedge clk);
    end
    wr(RSC_ADDR_RX_ONE, 8'h00);
    wr(RSC_ADDR_RX_TWO, 8'h80);
    rsc_feed_inst.send(1'b1, W'($random(seed)), 4'h0);
    chkS("rxOutSample", {W{1'b0}}, rxOutSample);
    chkR("rxOutChan", 10'h001, 10'(rxOutChan));
    // Converter mute; random traffic may have left the mute bit set
    wr(RSC_ADDR_DELAY_MUTE, 8'h00);
    x = W'($random(seed));
    x[W-1] = 1'b0;
    cvt(x);
    chkS("srcOutSample", x, srcOutSample);
    wr(RSC_ADDR_DELAY_MUTE, 8'h85);
    chkR("firExtraDelay", 10'h005, 10'(firExtraDelay));
    cvt(x);
    chkS("srcOutSample", x, srcOutSample);
    cvt(x);
    chkS("srcOutSample", W'(({8'h00, x} * 32'h3f) >> 6), srcOutSample);
    repeat (70) cvt(x);
    chkS("srcOutSample", {W{1'b0}}, srcOutSample);
    results();
  end

  // Watchdog: run needs about 500 cycles, allow thirty-fold
  initial
  begin
    #300000;
    bad_count++;
    results();
  end
endmodule
